// ===== src/sdoa_dec.sv
// Sextet to quintet decoder of one channel, with mode tracking
`timescale 1ns/1ns
`include "sdoa_params.svh"
module sdoa_dec import sdoa_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire sdoa_chin_type ch_i,
    output sdoa_dq_type dq_o
);
    typedef struct packed {
        sdoa_mode_type mode;
        sdoa_dq_type dq;
    } sdoa_dst_type;
    // Entry is {valid, quintet}; weight comes from the sextet itself
    localparam logic [0:63][5:0] TBL = {
        6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h30, 6'h2b, 6'h28,
        6'h00, 6'h32, 6'h24, 6'h27, 6'h20, 6'h23, 6'h26, 6'h00,
        6'h00, 6'h00, 6'h3e, 6'h3d, 6'h3a, 6'h25, 6'h33, 6'h2c,
        6'h35, 6'h36, 6'h2d, 6'h2e, 6'h3c, 6'h00, 6'h37, 6'h00,
        6'h00, 6'h37, 6'h22, 6'h29, 6'h2e, 6'h31, 6'h2a, 6'h35,
        6'h2c, 6'h2f, 6'h39, 6'h3a, 6'h21, 6'h3e, 6'h22, 6'h00,
        6'h00, 6'h38, 6'h3f, 6'h20, 6'h3b, 6'h24, 6'h32, 6'h00,
        6'h34, 6'h2b, 6'h30, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
    sdoa_dst_type st_r, st_nxt;
    function automatic logic [2:0] weight(input logic [5:0] s);
        logic [2:0] w;
        w = 3'h0;
        for (int k = 0; k < 6; k++) begin
            w = w + {2'h0, s[k]};
        end
        return w;
    endfunction
    always_comb begin
        sdoa_mode_type m;
        logic [2:0] w;
        m = st_r.mode;
        w = weight(ch_i.sextet);
        st_nxt = st_r;
        st_nxt.dq.valid = 1'b0;
        if (ch_i.valid && en_i) begin
            // A fresh channel stream opens in mode 2
            m = ch_i.first ? SDOA_M2 : st_r.mode; // RULE17
            st_nxt.dq.valid = 1'b1;
            st_nxt.dq.first = ch_i.first;
            st_nxt.dq.last = ch_i.last;
            st_nxt.dq.esd4 = ch_i.esd4;
            st_nxt.dq.q = TBL[ch_i.sextet][4:0]; // RULE1
            if (!TBL[ch_i.sextet][`SDOA_TBL_V]) begin
                st_nxt.dq.stat = SDOA_SERR; // RULE3 RULE16
            end else if (w == `SDOA_WT3) begin
                st_nxt.dq.stat = SDOA_S3; // RULE1 RULE16
            end else if (w == `SDOA_WT2 && m == SDOA_M2) begin
                st_nxt.dq.stat = SDOA_S2; // RULE2
                m = SDOA_M4; // RULE17
            end else if (w == `SDOA_WT4 && m == SDOA_M4) begin
                st_nxt.dq.stat = SDOA_S4; // RULE2
                m = SDOA_M2; // RULE17
            end else begin
                st_nxt.dq.stat = SDOA_SERR; // RULE2 RULE16
            end
            st_nxt.mode = m;
            st_nxt.dq.mode = m;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign dq_o = st_r.dq;
endmodule

// ===== src/sdoa_params.svh
// Constants for the sextet decoder and octet assembler
// What this block does
// RULE1 - Weight-3 sextets decode identically, both modes
// RULE2 - Mode 2 takes weight 2, mode 4 weight 4
// RULE3 - Invalid sextets always report error status
// RULE4 - Each channel deciphered by identical stream cipher
// RULE5 - Merge quintets cyclically, channel 0 to 3
// RULE6 - Valid end needs N3<=N2<=N0, N0-1<=N3
// RULE7 - Count rule violation marks last octet error
// RULE8 - Octets built earliest bit leftmost, order kept
// RULE9 - One data indication per assembled octet
// RULE10 - Every octet carries the packet priority
// RULE11 - First octet carries start-of-frame valid/invalid
// RULE12 - Position: begin first, end last, else more
// RULE13 - Leftover bits counted and discarded
// RULE14 - More than four leftover bits marks error
// RULE15 - Final mode against end delimiter, mismatch errors
// RULE16 - Status is weight 2, 3, 4 or error
// RULE17 - Mode toggles after weight 2 or 4
// RULE18 - Four decoders run parallel, each own decipher
`ifndef SDOA_PARAMS_SVH
`define SDOA_PARAMS_SVH
`define SDOA_NCH 4
`define SDOA_QB_AW 4
`define SDOA_NW 12
`define SDOA_N_ONE 12'h001
`define SDOA_LW 11
`define SDOA_SEED 11'h7ff
`define SDOA_TAP_A 10
`define SDOA_TAP_B 8
`define SDOA_TBL_V 5
`define SDOA_WT2 3'h2
`define SDOA_WT3 3'h3
`define SDOA_WT4 3'h4
`define SDOA_Q_W 4'h5
`define SDOA_OCT_W 4'h8
`define SDOA_EXT_MAX 4'h4
`define SDOA_REG_CTRL 3'h0
`define SDOA_REG_STAT 3'h1
`define SDOA_REG_MASK 3'h2
`define SDOA_REG_INFO 3'h3
`define SDOA_REG_NLO 3'h4
`define SDOA_REG_NHI 3'h5
`define SDOA_CTRL_EN 0
`define SDOA_CTRL_ABORT 1
`define SDOA_EN_RST 1'b1
`define SDOA_ST_W 6
`define SDOA_ST_DONE 0
`define SDOA_ST_CNT 1
`define SDOA_ST_EXT 2
`define SDOA_ST_DELIM 3
`define SDOA_ST_DEC 4
`define SDOA_ST_OVF 5
`endif

// ===== src/sdoa_pkg.sv
// Types shared by the sextet decoder and octet assembler
package sdoa_pkg;
`include "sdoa_params.svh"
typedef enum logic {SDOA_M2 = 1'b0, SDOA_M4 = 1'b1} sdoa_mode_type;
typedef enum logic [1:0] {
    SDOA_S2 = 2'b00,
    SDOA_S3 = 2'b01,
    SDOA_S4 = 2'b10,
    SDOA_SERR = 2'b11
} sdoa_stat_type;
typedef enum logic [1:0] {
    SDOA_BEGIN = 2'b00,
    SDOA_MORE = 2'b01,
    SDOA_END = 2'b10
} sdoa_pos_type;
typedef enum logic [1:0] {
    SDOA_IDLE = 2'b00,
    SDOA_RUN = 2'b01,
    SDOA_DRAIN = 2'b10,
    SDOA_FLUSH = 2'b11
} sdoa_mst_type;
typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic esd4;
    logic [5:0] sextet;
} sdoa_chin_type;
typedef struct packed {
    logic valid;
    logic sof_ok;
    logic prio;
} sdoa_start_type;
typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic esd4;
    sdoa_mode_type mode;
    sdoa_stat_type stat;
    logic [4:0] q;
} sdoa_dq_type;
typedef struct packed {
    logic valid;
    sdoa_pos_type pos;
    logic sof_ok;
    logic prio;
    logic err;
    logic [7:0] data;
} sdoa_oct_type;
endpackage

// ===== src/sdoa_qbuf.sv
// Quintet buffer of one channel with registered read data
`timescale 1ns/1ns
`include "sdoa_params.svh"
module sdoa_qbuf import sdoa_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [`SDOA_QB_AW-1:0] waddr_i,
    input wire logic [4:0] wdata_i,
    input wire logic [`SDOA_QB_AW-1:0] raddr_i,
    output logic [4:0] rdata_o
);
    typedef struct packed {
        logic [(1<<`SDOA_QB_AW)-1:0][4:0] mem;
        logic [4:0] rdata;
    } sdoa_qst_type;
    sdoa_qst_type st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (we_i) begin
            st_nxt.mem[waddr_i] = wdata_i;
        end
        st_nxt.rdata = st_r.mem[raddr_i];
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rdata_o = st_r.rdata;
endmodule

// ===== src/sdoa_top.sv
// Receive path: four decoders, decipher, merge and octet packing
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "sdoa_params.svh"
module sdoa_top import sdoa_pkg::*; (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire sdoa_start_type RX_START_I,
    input wire sdoa_chin_type [3:0] RX_CH_I,
    output sdoa_oct_type RX_OCT_O,
    output logic IRQ_O
);
    typedef struct packed {
        logic [12:0] acc;
        logic [3:0] cnt;
        logic ov;
        logic [7:0] oct;
    } sdoa_pk_type;
    typedef struct packed {
        sdoa_mst_type mst;
        logic [1:0] rr;
        logic rd_v;
        logic [1:0] rd_ch;
        logic [3:0][`SDOA_QB_AW:0] wp;
        logic [3:0][`SDOA_QB_AW:0] rp;
        logic [3:0][`SDOA_NW-1:0] n;
        logic [3:0][`SDOA_LW-1:0] lfsr;
        logic [3:0] done;
        logic [12:0] acc;
        logic [3:0] cnt;
        logic pend_v;
        logic [7:0] pend;
        logic sent;
        logic sof_ok;
        logic prio;
        logic dec_err;
        logic delim_err;
        logic ovf;
        sdoa_oct_type oct;
        logic en;
        logic [`SDOA_ST_W-1:0] stat;
        logic [`SDOA_ST_W-1:0] mask;
        logic [3:0] ext;
        logic [15:0] octs;
        logic wait_rq;
        logic [31:0] rdata;
        logic irq;
    } sdoa_tst_type;

    sdoa_tst_type st_r, st_nxt;
    sdoa_dq_type [3:0] dq;
    logic [3:0] we;
    logic [3:0][`SDOA_QB_AW-1:0] waddr;
    logic [3:0][`SDOA_QB_AW-1:0] raddr;
    logic [3:0][4:0] wdata;
    logic [3:0][4:0] rdata;

    // Additive keystream, restarted at each channel's first quintet
    function automatic logic [`SDOA_LW+4:0] decipher(
        input logic [`SDOA_LW-1:0] l0,
        input logic [4:0] q
    );
        logic [`SDOA_LW-1:0] l;
        logic [4:0] o;
        l = l0;
        o = q;
        for (int k = 4; k >= 0; k--) begin
            o[k] = o[k] ^ l[`SDOA_LW-1];
            l = {l[`SDOA_LW-2:0], l[`SDOA_TAP_A] ^ l[`SDOA_TAP_B]};
        end
        return {l, o};
    endfunction

    // Appends a quintet below the held bits; oldest bit is the MSB
    function automatic sdoa_pk_type pack(
        input logic [12:0] acc,
        input logic [3:0] cnt,
        input logic [4:0] q
    );
        sdoa_pk_type r;
        logic [12:0] v;
        logic [3:0] c;
        v = {acc[7:0], q};
        c = cnt + `SDOA_Q_W;
        r.ov = (c >= `SDOA_OCT_W);
        r.oct = 8'h00;
        if (r.ov) begin
            r.oct = 8'(v >> (c - `SDOA_OCT_W));
            c = c - `SDOA_OCT_W;
        end
        r.acc = v & ((13'h0001 << c) - 13'h0001);
        r.cnt = c;
        return r;
    endfunction

    function automatic logic is_empty(
        input logic [`SDOA_QB_AW:0] wp,
        input logic [`SDOA_QB_AW:0] rp
    );
        return wp == rp;
    endfunction

    function automatic logic is_full(
        input logic [`SDOA_QB_AW:0] wp,
        input logic [`SDOA_QB_AW:0] rp
    );
        return (wp[`SDOA_QB_AW] != rp[`SDOA_QB_AW]) &&
            (wp[`SDOA_QB_AW-1:0] == rp[`SDOA_QB_AW-1:0]);
    endfunction

    function automatic sdoa_oct_type mk_oct(
        input logic [7:0] d,
        input sdoa_pos_type pos,
        input logic err,
        input logic sof_ok,
        input logic prio
    );
        sdoa_oct_type o;
        o.valid = 1'b1;
        o.pos = pos;
        o.err = err;
        o.sof_ok = sof_ok;
        o.prio = prio;
        o.data = d;
        return o;
    endfunction

    genvar g;
    generate
        for (g = 0; g < `SDOA_NCH; g++) begin : g_ch
            sdoa_dec u_dec (
                .clk_i(CLK_I),
                .nrst_i(NRST_I),
                .en_i(st_r.en),
                .ch_i(RX_CH_I[g]),
                .dq_o(dq[g])
            );
            sdoa_qbuf u_buf (
                .clk_i(CLK_I),
                .nrst_i(NRST_I),
                .we_i(we[g]),
                .waddr_i(waddr[g]),
                .wdata_i(wdata[g]),
                .raddr_i(raddr[g]),
                .rdata_o(rdata[g])
            );
        end
    endgenerate

    always_comb begin
        logic [4:0] wq;
        logic [1:0] c;
        sdoa_pk_type pk;
        logic abort;
        logic bad_n;
        logic bad_x;
        logic bad;
        wq = 5'h00;
        c = st_r.rr;
        pk = '0;
        abort = 1'b0;
        bad_n = 1'b0;
        bad_x = 1'b0;
        bad = 1'b0;
        st_nxt = st_r;
        st_nxt.oct.valid = 1'b0;
        st_nxt.rd_v = 1'b0;
        we = '0;
        waddr = '0;
        wdata = '0;
        raddr = '0;

        // Bus: one wait cycle, then one acknowledge cycle
        if (!st_r.wait_rq) begin
            st_nxt.wait_rq = 1'b1;
            if (AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
                case (AVS_ADDRESS_I)
                    `SDOA_REG_CTRL: begin
                        st_nxt.en = AVS_WRITEDATA_I[`SDOA_CTRL_EN];
                        abort = AVS_WRITEDATA_I[`SDOA_CTRL_ABORT];
                    end
                    `SDOA_REG_STAT: begin
                        st_nxt.stat = st_r.stat &
                            ~AVS_WRITEDATA_I[`SDOA_ST_W-1:0];
                    end
                    `SDOA_REG_MASK: begin
                        st_nxt.mask = AVS_WRITEDATA_I[`SDOA_ST_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end else if (AVS_READ_I || AVS_WRITE_I) begin
            st_nxt.wait_rq = 1'b0;
            case (AVS_ADDRESS_I)
                `SDOA_REG_CTRL: st_nxt.rdata = 32'(st_r.en);
                `SDOA_REG_STAT: st_nxt.rdata = 32'(st_r.stat);
                `SDOA_REG_MASK: st_nxt.rdata = 32'(st_r.mask);
                `SDOA_REG_INFO: begin
                    st_nxt.rdata = {st_r.octs, 12'h000, st_r.ext};
                end
                `SDOA_REG_NLO: begin
                    st_nxt.rdata = {4'h0, st_r.n[1], 4'h0, st_r.n[0]};
                end
                `SDOA_REG_NHI: begin
                    st_nxt.rdata = {4'h0, st_r.n[3], 4'h0, st_r.n[2]};
                end
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end

        // A new packet is only taken while idle
        if (RX_START_I.valid && st_r.en && st_r.mst == SDOA_IDLE) begin
            st_nxt.mst = SDOA_RUN;
            st_nxt.rr = 2'h0;
            st_nxt.wp = '0;
            st_nxt.rp = '0;
            st_nxt.n = '0;
            st_nxt.done = '0;
            st_nxt.acc = '0;
            st_nxt.cnt = 4'h0;
            st_nxt.pend_v = 1'b0;
            st_nxt.sent = 1'b0;
            st_nxt.dec_err = 1'b0;
            st_nxt.delim_err = 1'b0;
            st_nxt.ovf = 1'b0;
            st_nxt.octs = 16'h0000;
            st_nxt.sof_ok = RX_START_I.sof_ok; // RULE11
            st_nxt.prio = RX_START_I.prio; // RULE10
        end

        // Per-channel decipher into the channel's own buffer
        for (int i = 0; i < `SDOA_NCH; i++) begin
            if (dq[i].valid && st_r.mst == SDOA_RUN && !st_r.done[i]) begin
                {st_nxt.lfsr[i], wq} = decipher(
                    dq[i].first ? `SDOA_SEED : st_r.lfsr[i],
                    dq[i].q); // RULE4 RULE18
                // Skew beyond the buffer depth is lost and reported
                if (is_full(st_r.wp[i], st_r.rp[i])) begin
                    st_nxt.ovf = 1'b1;
                end else begin
                    we[i] = 1'b1;
                    waddr[i] = st_r.wp[i][`SDOA_QB_AW-1:0];
                    wdata[i] = wq;
                    st_nxt.wp[i] = st_r.wp[i] + 1'b1;
                    st_nxt.n[i] = st_r.n[i] + `SDOA_N_ONE;
                end
                if (dq[i].stat == SDOA_SERR) begin
                    st_nxt.dec_err = 1'b1;
                end
                if (dq[i].last) begin
                    st_nxt.done[i] = 1'b1;
                    if ((dq[i].mode == SDOA_M2) == dq[i].esd4) begin
                        st_nxt.delim_err = 1'b1; // RULE15
                    end
                end
            end
        end

        // Read data arrive one cycle after the address
        if (st_r.rd_v) begin
            pk = pack(st_r.acc, st_r.cnt, rdata[st_r.rd_ch]); // RULE8
            st_nxt.acc = pk.acc;
            st_nxt.cnt = pk.cnt;
            if (pk.ov) begin
                // One octet is held back so the last can be tagged end
                if (st_r.pend_v) begin
                    st_nxt.oct = mk_oct(st_r.pend,
                        st_r.sent ? SDOA_MORE : SDOA_BEGIN, 1'b0,
                        st_r.sof_ok, st_r.prio); // RULE9 RULE12
                    st_nxt.sent = 1'b1;
                    st_nxt.octs = st_r.octs + 16'h0001;
                end
                st_nxt.pend = pk.oct;
                st_nxt.pend_v = 1'b1;
            end
        end

        unique case (st_r.mst)
            SDOA_IDLE: begin
            end
            SDOA_RUN: begin
                if (!is_empty(st_r.wp[c], st_r.rp[c])) begin
                    raddr[c] = st_r.rp[c][`SDOA_QB_AW-1:0]; // RULE5
                    st_nxt.rp[c] = st_r.rp[c] + 1'b1;
                    st_nxt.rd_v = 1'b1;
                    st_nxt.rd_ch = c;
                    st_nxt.rr = 2'(c + 2'h1); // RULE5
                end else if (st_r.done[c] && (&st_r.done)) begin
                    st_nxt.mst = SDOA_DRAIN;
                end
            end
            SDOA_DRAIN: begin
                st_nxt.mst = SDOA_FLUSH;
            end
            SDOA_FLUSH: begin
                bad_n = !((st_r.n[3] <= st_r.n[2]) &&
                    (st_r.n[2] <= st_r.n[0]) &&
                    ((st_r.n[0] - st_r.n[3]) <= `SDOA_N_ONE)); // RULE6
                bad_x = st_r.cnt > `SDOA_EXT_MAX; // RULE14
                bad = bad_n || bad_x || st_r.delim_err ||
                    st_r.dec_err || st_r.ovf;
                if (st_r.pend_v) begin
                    st_nxt.oct = mk_oct(st_r.pend, SDOA_END, bad,
                        st_r.sof_ok, st_r.prio); // RULE7 RULE12
                    st_nxt.octs = st_r.octs + 16'h0001;
                end
                st_nxt.pend_v = 1'b0;
                st_nxt.ext = st_r.cnt; // RULE13
                st_nxt.acc = '0; // RULE13
                st_nxt.cnt = 4'h0;
                st_nxt.stat[`SDOA_ST_DONE] = 1'b1;
                st_nxt.stat[`SDOA_ST_CNT] =
                    st_nxt.stat[`SDOA_ST_CNT] | bad_n; // RULE7
                st_nxt.stat[`SDOA_ST_EXT] =
                    st_nxt.stat[`SDOA_ST_EXT] | bad_x;
                st_nxt.stat[`SDOA_ST_DELIM] =
                    st_nxt.stat[`SDOA_ST_DELIM] | st_r.delim_err;
                st_nxt.stat[`SDOA_ST_DEC] =
                    st_nxt.stat[`SDOA_ST_DEC] | st_r.dec_err;
                st_nxt.stat[`SDOA_ST_OVF] =
                    st_nxt.stat[`SDOA_ST_OVF] | st_r.ovf;
                st_nxt.mst = SDOA_IDLE;
            end
        endcase

        // Abort drops the packet; an end octet built in the same flush cycle still goes out
        if (abort) begin
            st_nxt.mst = SDOA_IDLE;
            st_nxt.pend_v = 1'b0;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_r <= '0;
            st_r.wait_rq <= 1'b1;
            st_r.en <= `SDOA_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign AVS_READDATA_O = st_r.rdata;
    assign AVS_WAITREQUEST_O = st_r.wait_rq;
    assign RX_OCT_O = st_r.oct;
    assign IRQ_O = st_r.irq;
endmodule

// ===== tb/sdoa_mac_model.sv
// Octet sink standing in for the MAC
`timescale 1ns/1ns
module sdoa_mac_model import sdoa_pkg::*; (
    input wire logic clk_i,
    input wire sdoa_oct_type oct_i
);
    // Every indication kept in arrival order for the bench to judge
    sdoa_oct_type got [$];
    always @(posedge clk_i) begin
        if (oct_i.valid === 1'b1) begin
            got.push_back(oct_i);
        end
    end
endmodule

// ===== tb/sdoa_top_sva.sv
// Port checker of the receive path block
`timescale 1ns/1ns
module sdoa_top_sva import sdoa_pkg::*; (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire sdoa_start_type RX_START_I,
    input wire sdoa_oct_type RX_OCT_O
);
    logic busy_r, seen_r, prio_r, sof_r, req, wq;
    sdoa_oct_type o;
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign wq = AVS_WAITREQUEST_O;
    assign o = RX_OCT_O;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // Packet window seen at the ports; a start while busy is ignored
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_r <= 1'b0;
            seen_r <= 1'b0;
            prio_r <= 1'b0;
            sof_r <= 1'b0;
        end else begin
            if (RX_START_I.valid && !busy_r) begin
                busy_r <= 1'b1;
                prio_r <= RX_START_I.prio;
                sof_r <= RX_START_I.sof_ok;
            end else if (o.valid && o.pos == SDOA_END) begin
                busy_r <= 1'b0;
            end
            if (o.valid) begin
                seen_r <= o.pos != SDOA_END;
            end
        end
    end
    a_wait_answer: assert property (req && wq |=> !wq)
        else $error("request not answered");
    a_ack_single: assert property (!wq |=> wq)
        else $error("ack too long");
    a_unmapped_read: assert property (AVS_READ_I && wq &&
        AVS_ADDRESS_I[2:1] == 2'b11 |=> AVS_READDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_octet_in_pkt: assert property (o.valid |-> busy_r)
        else $error("octet outside packet");
    a_pos_first: assert property (
        o.valid && !seen_r |-> o.pos != SDOA_MORE)
        else $error("first octet position");
    a_pos_later: assert property (
        o.valid && seen_r |-> o.pos != SDOA_BEGIN)
        else $error("later octet position");
    a_prio_held: assert property (
        o.valid |-> o.prio == prio_r && o.sof_ok == sof_r)
        else $error("priority or start status changed");
    a_err_last: assert property (
        o.valid && o.pos != SDOA_END |-> !o.err)
        else $error("error before last octet");
endmodule
bind sdoa_top sdoa_top_sva i_sva (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .RX_START_I(RX_START_I),
    .RX_OCT_O(RX_OCT_O)
);

// ===== tb/sdoa_top_test.sv
// Self-checking bench of the receive path block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module sdoa_top_test import sdoa_pkg::*; ;
    localparam logic [5:0] A = 6'h23, B = 6'h25, C = 6'h29;
    localparam logic [5:0] D = 6'h31, W2 = 6'h21, W4 = 6'h27;
    logic clk, nrst, rd, wr, wq, irq;
    logic [2:0] adr;
    logic [31:0] wd, rdat, rs;
    sdoa_start_type st_r;
    sdoa_chin_type [3:0] ch_r;
    sdoa_oct_type oct;
    int error_cnt, samples_checked, cyc;
    int n [4];
    logic esd [4];
    logic [5:0] sx [4][3];
    logic [5:0] ts [6] = '{6'h20, 6'h3f, W4, A, W2, W2};
    logic te [6] = '{0, 0, 0, 1, 0, 1};
    sdoa_top i_dut (.CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wq), .RX_START_I(st_r), .RX_CH_I(ch_r),
        .RX_OCT_O(oct), .IRQ_O(irq));
    sdoa_mac_model i_mac (.clk_i(clk), .oct_i(oct));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hang anywhere ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic bus(input logic w, input logic [2:0] a,
            input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do
            @(posedge clk);
        while (wq !== 1'b0);
        rs = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] dec(input logic [5:0] s);
        case (s)
            A: return 8'h69;
            B: return 8'h71;
            C: return 8'h6f;
            D: return 8'h78;
            W2: return 8'h57;
            W4: return 8'h95;
            default: return 8'h0;
        endcase
    endfunction
    function automatic logic [4:0] ciph(input logic [4:0] q,
            inout logic [10:0] l);
        for (int b = 4; b >= 0; b--) begin
            q[b] = q[b] ^ l[10];
            l = {l[9:0], l[10] ^ l[8]};
        end
        return q;
    endfunction
    task automatic ld(input int c, input int k, input logic e,
            input logic [17:0] s);
        n[c] = k;
        esd[c] = e;
        sx[c] = '{s[17:12], s[11:6], s[5:0]};
    endtask
    task automatic run(input logic pr, input logic so);
        logic [4:0] q [4][3];
        logic [10:0] l;
        logic [7:0] d;
        logic [5:0] es;
        logic m;
        logic bq [$];
        int k, c, no, ext;
        sdoa_oct_type o;
        bus(1'b1, 3'h1, 32'h3f);
        es = 6'h1;
        for (c = 0; c < 4; c++) begin
            l = 11'h7ff;
            m = 1'b0;
            for (k = 0; k < n[c]; k++) begin
                d = dec(sx[c][k]);
                if (d[7:5] == 3'h0 || d[7:5] == (m ? 3'h2 : 3'h4))
                    es[4] = 1'b1;
                else if (d[7:5] != 3'h3)
                    m = !m;
                q[c][k] = ciph(d[4:0], l);
            end
            if (m != esd[c])
                es[3] = 1'b1;
        end
        if (n[3] > n[2] || n[2] > n[0] || n[0] - 1 > n[3])
            es[1] = 1'b1;
        k = 0;
        c = 0;
        while (k < n[c]) begin
            for (int b = 4; b >= 0; b--)
                bq.push_back(q[c][k][b]);
            c = (c + 1) % 4;
            if (c == 0)
                k++;
        end
        no = bq.size() / 8;
        ext = bq.size() % 8;
        if (ext > 4)
            es[2] = 1'b1;
        i_mac.got.delete();
        for (k = 0; k < 4; k++) begin
            st_r <= k == 0 ? {1'b1, so, pr} : 3'h0;
            for (c = 0; c < 4; c++)
                ch_r[c] <= k < n[c] ? {1'b1, k == 0, k == n[c] - 1,
                    esd[c], sx[c][k % 3]} : 10'h0;
            @(posedge clk);
        end
        while (!(i_mac.got.size() > 0 &&
                i_mac.got[$].pos === SDOA_END))
            @(posedge clk);
        `CHK("octets", no, i_mac.got.size())
        for (k = 0; k < no && k < i_mac.got.size(); k++) begin
            o = i_mac.got[k];
            for (c = 0; c < 8; c++)
                d = {d[6:0], bq[8 * k + c]};
            if (!es[4])
                `CHK("data", d, o.data)
            `CHK("pos", k == no - 1 ? SDOA_END : k == 0 ? SDOA_BEGIN :
                SDOA_MORE, o.pos)
            `CHK("err", k == no - 1 && es[4:1] != 0, o.err)
            `CHK("prio", pr, o.prio)
            `CHK("sof", so, o.sof_ok)
        end
        bus(1'b0, 3'h1, 32'h0);
        `CHK("status", {26'h0, es}, rs)
        bus(1'b0, 3'h3, 32'h0);
        `CHK("info", {no[15:0], 12'h0, ext[3:0]}, rs)
    endtask
    initial begin
        nrst = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 3'h0;
        wd = 32'h0;
        st_r = '0;
        ch_r = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(1'b1, 3'h7, 32'hffff);
        bus(1'b0, 3'h6, 32'h0);
        `CHK("unmapped", 32'h0, rs)
        bus(1'b0, 3'h0, 32'h0);
        `CHK("ctrl reset", 32'h1, rs)
        ld(0, 2, 0, {A, B, C});
        ld(1, 2, 0, {C, D, A});
        ld(2, 2, 0, {D, A, B});
        ld(3, 2, 0, {B, C, D});
        run(1'b1, 1'b0);
        bus(1'b0, 3'h4, 32'h0);
        `CHK("count lo", 32'h20002, rs)
        bus(1'b0, 3'h5, 32'h0);
        `CHK("count hi", 32'h20002, rs)
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, 3'h2, 32'h1);
        @(posedge clk);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, 3'h1, 32'h1);
        @(posedge clk);
        `CHK("irq clear", 1'b0, irq)
        // Mode walk on channel 0 and five leftover bits
        ld(0, 3, 0, {W2, W4, A});
        ld(1, 2, 0, {B, C, D});
        ld(2, 2, 0, {C, A, B});
        ld(3, 2, 0, {D, B, A});
        run(1'b0, 1'b1);
        for (int c = 0; c < 4; c++)
            ld(c, 1, 0, {D, A, B});
        run(1'b1, 1'b1);
        ld(2, 2, 0, {A, B, C});
        run(1'b0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            for (int c = 0; c < 4; c++)
                ld(c, 1, 0, {A, A, A});
            ld(1, 1, te[i], {ts[i], A, A});
            run(i[0], 1'b1);
        end
        bus(1'b1, 3'h0, 32'h2);
        bus(1'b0, 3'h0, 32'h0);
        `CHK("ctrl off", 32'h0, rs)
        finish_test();
    end
endmodule
